// [smwi_wait_inserter.sv]
/*
 * Wait-state inserter of the static memory controller: decides how many
 * idle cycles separate external accesses and holds the next one back.
 * Assumes a waveform generator that starts an access when a request is
 * taken and pulses access_end_in at the end of its hold phase, and a
 * master that holds a request stable until it is taken.
 */
`default_nettype none

module smwi_wait_inserter #(
    parameter int NUM_CS = 8
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire smwi_pkg::smwi_cfg_type cfg_in [NUM_CS],
    input wire logic req_valid_in,
    input wire smwi_pkg::smwi_req_type req_in,
    output logic req_ready_out,
    input wire logic access_end_in,
    input wire logic mode_reg_write_in,
    input wire logic slow_clock_in,
    input wire logic write_strobe_fb_n_in,
    output logic strobes_off_out,
    output logic bus_hold_out,
    output logic load_config_out,
    output logic reload_pending_out,
    output smwi_pkg::smwi_wait_type wait_kind_out,
    output logic [smwi_pkg::FLOAT_W-1:0] float_remaining_out
);

    typedef enum {ST_IDLE, ST_WAIT, ST_READY, ST_ACCESS} smwi_state_type;

    smwi_state_type state_reg;
    smwi_pkg::smwi_cfg_type ncfg;
    smwi_pkg::smwi_cfg_type pcfg;
    smwi_pkg::smwi_cfg_type ecfg;
    smwi_pkg::smwi_wait_type kind;
    smwi_pkg::smwi_req_type cur_reg;
    logic [smwi_pkg::WAIT_W-1:0] cnt_reg;
    logic [smwi_pkg::WAIT_W-1:0] fixed;
    logic [smwi_pkg::WAIT_W-1:0] total;
    logic [smwi_pkg::WAIT_W-1:0] need;
    logic [smwi_pkg::TIME_W-1:0] setup_next;
    logic [smwi_pkg::TIME_W-1:0] read_hold;
    logic [smwi_pkg::FLOAT_W-1:0] float_load;
    logic [smwi_pkg::CS_W-1:0] prev_cs_reg;
    logic prev_valid_reg;
    logic prev_write_reg;
    logic fb_late_reg;
    logic reload_pend_reg;
    logic slow_prev_reg;
    logic fb_n_sync;
    logic decide;
    logic ext_grant;
    logic cs_change;
    logic early_cond;
    logic float_apply;
    logic read_end;

    // ------------------------------------------------------------------
    // Pad feedback and float timer
    // ------------------------------------------------------------------
    smwi_sync2 #(
        .RESET_VAL(1'b1)
    ) u_fb_sync (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .d_in(write_strobe_fb_n_in),
        .q_out(fb_n_sync)
    );

    assign read_end = (state_reg == ST_ACCESS) && access_end_in && !cur_reg.is_write;

    smwi_float_timer #(
        .W(smwi_pkg::FLOAT_W)
    ) u_float (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .load_in(read_end),
        .load_val_in(float_load),
        .remaining_out(float_remaining_out)
    );

    // Float period left at read end: hold cycles already spent count
    always_comb begin
        ecfg = cfg_in[cur_reg.cs];
        read_hold = ecfg.read_ctrl_sel ? ecfg.read_strobe_hold
                                       : ecfg.cs_read_hold;
        if ({4'h0, ecfg.float_cycles} > read_hold) begin
            float_load = ecfg.float_cycles - read_hold[smwi_pkg::FLOAT_W-1:0];
        end else begin
            float_load = smwi_pkg::FLOAT_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // Wait decision for the request now offered
    // ------------------------------------------------------------------
    assign decide = (state_reg == ST_IDLE) && req_valid_in && !req_in.internal;

    always_comb begin
        ncfg = cfg_in[req_in.cs];
        pcfg = cfg_in[prev_cs_reg];
        cs_change = prev_valid_reg && (req_in.cs != prev_cs_reg);
        // Any of the three write-then-read hazards
        early_cond = ((pcfg.write_ctrl_sel ? pcfg.write_strobe_hold == smwi_pkg::TIME_ZERO
                                           : pcfg.cs_write_hold == smwi_pkg::TIME_ZERO)
                      && (ncfg.read_ctrl_sel ? ncfg.read_strobe_setup == smwi_pkg::TIME_ZERO
                                             : ncfg.cs_read_setup == smwi_pkg::TIME_ZERO))
                     || (!pcfg.write_ctrl_sel && pcfg.cs_write_hold == smwi_pkg::TIME_ZERO
                         && ncfg.cs_read_setup == smwi_pkg::TIME_ZERO)
                     || (pcfg.write_ctrl_sel && pcfg.write_strobe_hold == smwi_pkg::TIME_ZERO
                         && fb_late_reg);
        // Setup of the next access, used only with float optimisation
        if (req_in.is_write) begin
            setup_next = ncfg.write_ctrl_sel ? ncfg.write_strobe_setup : ncfg.cs_write_setup;
        end else begin
            setup_next = ncfg.read_ctrl_sel ? ncfg.read_strobe_setup : ncfg.cs_read_setup;
        end
        if (!pcfg.float_opt) begin
            need = {1'b0, float_remaining_out};
        end else if ({4'h0, float_remaining_out} > setup_next) begin
            need = {1'b0, float_remaining_out - setup_next[smwi_pkg::FLOAT_W-1:0]};
        end else begin
            need = smwi_pkg::WAIT_ZERO;
        end
        float_apply = prev_valid_reg && !prev_write_reg
                      && (req_in.is_write || cs_change);
        kind.cs_change = cs_change;
        kind.reload = reload_pend_reg && !cs_change;
        kind.early_read = !cs_change && prev_valid_reg && prev_write_reg
                          && !req_in.is_write && early_cond;
        kind.read_to_write = prev_valid_reg && !prev_write_reg && req_in.is_write;
        kind.data_float = float_apply && (need != smwi_pkg::WAIT_ZERO);
        // Merged idle cycle plus the separate read-to-write cycle
        fixed = ((kind.cs_change || kind.reload || kind.early_read) ? smwi_pkg::WAIT_ONE
                                                                    : smwi_pkg::WAIT_ZERO)
                + (kind.read_to_write ? smwi_pkg::WAIT_ONE : smwi_pkg::WAIT_ZERO);
        // Fixed wait cycles also let the float period run out
        total = (kind.data_float && need > fixed) ? need : fixed;
    end

    // External grant waits for all wait cycles; internal ones never do
    assign ext_grant = (decide && total == smwi_pkg::WAIT_ZERO)
                       || ((state_reg == ST_READY) && req_valid_in && !req_in.internal);
    assign req_ready_out = req_in.internal || ext_grant;
    assign strobes_off_out = (state_reg == ST_WAIT);
    assign reload_pending_out = reload_pend_reg;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= ST_IDLE;
            cnt_reg <= smwi_pkg::WAIT_ZERO;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (ext_grant) begin
                        state_reg <= ST_ACCESS;
                    end else if (decide) begin
                        state_reg <= ST_WAIT;
                        cnt_reg <= total;
                    end
                end
                ST_WAIT: begin
                    // No setup phase until the last wait cycle has passed
                    cnt_reg <= cnt_reg - smwi_pkg::WAIT_ONE;
                    if (cnt_reg == smwi_pkg::WAIT_ONE) begin
                        state_reg <= ST_READY;
                    end
                end
                ST_READY: begin
                    if (ext_grant) begin
                        state_reg <= ST_ACCESS;
                    end
                end
                ST_ACCESS: begin
                    if (access_end_in) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Current and previous external access
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            cur_reg <= '0;
            prev_valid_reg <= 1'b0;
            prev_cs_reg <= smwi_pkg::CS_RESET;
            prev_write_reg <= 1'b0;
            fb_late_reg <= 1'b0;
        end else begin
            if (ext_grant) begin
                cur_reg <= req_in;
            end
            if ((state_reg == ST_ACCESS) && access_end_in) begin
                prev_valid_reg <= 1'b1;
                prev_cs_reg <= cur_reg.cs;
                prev_write_reg <= cur_reg.is_write;
                // Strobe still low at write end means the pad lagged
                fb_late_reg <= cur_reg.is_write && !fb_n_sync;
            end
        end
    end

    // ------------------------------------------------------------------
    // Reload request: a mode write or a slow clock transition
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            reload_pend_reg <= 1'b0;
            slow_prev_reg <= smwi_pkg::SLOW_RESET;
            load_config_out <= 1'b0;
        end else begin
            slow_prev_reg <= slow_clock_in;
            load_config_out <= decide && reload_pend_reg;
            // A new trigger in the consuming cycle wins over the clear
            if (mode_reg_write_in || (slow_clock_in != slow_prev_reg)) begin
                reload_pend_reg <= 1'b1;
            end else if (decide) begin
                reload_pend_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Wait reasons and bus hold for late write strobe feedback
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            wait_kind_out <= smwi_pkg::WAIT_NONE;
            bus_hold_out <= 1'b0;
        end else begin
            if (decide) begin
                wait_kind_out <= kind;
                bus_hold_out <= kind.early_read && pcfg.write_ctrl_sel && fb_late_reg;
            end else if (state_reg != ST_WAIT) begin
                bus_hold_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (reset_in);

    // A chip-select wait alone must separate the accesses: exactly one wait cycle
    chk_early_not_cs: assert property (decide && cs_change && !kind.read_to_write
                                       && !kind.data_float |-> !kind.early_read
                                       ##1 (state_reg == ST_WAIT
                                            && cnt_reg == smwi_pkg::WAIT_ONE))
        else $error("early-read wait merged with chip-select wait");
    chk_early_same_cs: assert property (kind.early_read && decide
                                        |-> prev_write_reg && !req_in.is_write
                                            && req_in.cs == prev_cs_reg)
        else $error("early-read wait outside write then read");
    chk_r2w_counted: assert property (decide && prev_valid_reg && !prev_write_reg
                                      && req_in.is_write |=> cnt_reg >= 5'h01)
        else $error("read to write without wait cycle");
    chk_r2w_added: assert property (decide && kind.read_to_write
                                    && (cs_change || reload_pend_reg)
                                    |=> (state_reg == ST_WAIT) [*2])
        else $error("read-to-write wait merged with other wait");
    chk_reload_cs: assert property (decide && cs_change |-> !kind.reload)
        else $error("reload wait added on chip select change");
    chk_reload_load: assert property (decide && reload_pend_reg
                                      |=> load_config_out && state_reg == ST_WAIT)
        else $error("reload pending without load in a wait cycle");
    chk_mode_pend: assert property (mode_reg_write_in |=> reload_pend_reg)
        else $error("mode write lost");
    chk_internal_pass: assert property (req_valid_in && req_in.internal |-> req_ready_out)
        else $error("internal access stalled");
    chk_wait_quiet: assert property (state_reg == ST_WAIT |-> strobes_off_out
                                     && !ext_grant
                                     && cnt_reg != smwi_pkg::WAIT_ZERO)
        else $error("access started during wait");
    chk_float_run: assert property (read_end |=> float_remaining_out == $past(float_load))
        else $error("float timer not loaded at read end");

    cov_early: cover property (decide && kind.early_read);
    cov_float: cover property (decide && kind.data_float && total >= 5'h02);
    cov_reload: cover property (decide && kind.reload && kind.read_to_write);

endmodule

`default_nettype wire

// [smwi_pkg.sv]
/*
 * Shared types and constants of the static memory wait-state inserter.
 * Assumes a single master clock domain; every user of these items names
 * them with the package prefix.
 */
`default_nettype none

package smwi_pkg;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int CS_W = 3;
    localparam int TIME_W = 8;
    localparam int FLOAT_W = 4;
    localparam int WAIT_W = 5;
    localparam logic [CS_W-1:0] CS_RESET = 3'h0;
    localparam logic [WAIT_W-1:0] WAIT_ZERO = 5'h00;
    localparam logic [WAIT_W-1:0] WAIT_ONE = 5'h01;
    localparam logic [FLOAT_W-1:0] FLOAT_ZERO = 4'h0;
    localparam logic [TIME_W-1:0] TIME_ZERO = 8'h00;
    localparam logic SLOW_RESET = 1'b0;

    // ------------------------------------------------------------------
    // Per chip select configuration, timings in master clock cycles
    // ------------------------------------------------------------------
    typedef struct packed {
        logic write_ctrl_sel;                   // 1: write strobe, 0: chip select
        logic read_ctrl_sel;                    // 1: read strobe, 0: chip select
        logic float_opt;                        // Data-float optimisation enable
        logic [FLOAT_W-1:0] float_cycles;       // Data-float cycles, 0 to 15
        logic [TIME_W-1:0] write_strobe_setup;
        logic [TIME_W-1:0] write_strobe_hold;
        logic [TIME_W-1:0] cs_write_setup;
        logic [TIME_W-1:0] cs_write_hold;
        logic [TIME_W-1:0] read_strobe_setup;
        logic [TIME_W-1:0] read_strobe_hold;
        logic [TIME_W-1:0] cs_read_setup;
        logic [TIME_W-1:0] cs_read_hold;
    } smwi_cfg_type;

    // Access request from the internal bus master
    typedef struct packed {
        logic [CS_W-1:0] cs;
        logic is_write;
        logic internal;                         // Targets on-chip memory
    } smwi_req_type;

    // Reasons behind the wait cycles before the latest external access
    typedef struct packed {
        logic cs_change;
        logic reload;
        logic early_read;
        logic read_to_write;
        logic data_float;
    } smwi_wait_type;

    localparam smwi_wait_type WAIT_NONE = 5'h00;

endpackage

`default_nettype wire

// [smwi_sync2.sv]
/*
 * Two flip-flop synchroniser for one level arriving from a pad.
 * Assumes the level may change at any time relative to mclk_in.
 */
`default_nettype none

module smwi_sync2 #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic d_in,
    output logic q_out
);

    logic meta_reg;

    // ----------------------------------------------------------------
    // Synchroniser chain; only the second stage is visible outside
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_reg <= RESET_VAL;
            q_out <= RESET_VAL;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// [smwi_float_timer.sv]
/*
 * Down counter of the data-float period still to run after a read.
 * Assumes load_in pulses once when a read ends on the external bus.
 */
`default_nettype none

module smwi_float_timer #(
    parameter int W = smwi_pkg::FLOAT_W
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic load_in,
    input wire logic [W-1:0] load_val_in,
    output logic [W-1:0] remaining_out
);

    // ----------------------------------------------------------------
    // Counter: load wins, otherwise count down to zero and rest there
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            remaining_out <= '0;
        end else if (load_in) begin
            remaining_out <= load_val_in;
        end else if (remaining_out != '0) begin
            remaining_out <= remaining_out - W'(1);
        end
    end

endmodule

`default_nettype wire

// [smwi_mem_model.sv]
/*
 * Behavioural model of the external memory and waveform generator.
 * Assumes one external access at a time, each four master clock cycles long.
 */
`default_nettype none

module smwi_mem_model (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic take_in,
    input wire logic is_write_in,
    input wire logic late_in,
    output logic access_end_out,
    output logic fb_n_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Access timing
    // ----------------------------------------
    logic [2:0] cnt_reg;
    logic wr_reg;
    logic late_reg;
    // Access runs four cycles from the edge that takes it
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_reg <= 3'h0;
            wr_reg <= 1'b0;
            late_reg <= 1'b0;
        end else if (take_in) begin
            cnt_reg <= 3'h4;
            wr_reg <= is_write_in;
            late_reg <= late_in;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
        end
    end
    assign access_end_out = (cnt_reg == 3'h1);
    // Strobe pad returns high early unless a heavy load keeps it low to the end
    assign fb_n_out = !(wr_reg && (cnt_reg == 3'h4 || (late_reg && cnt_reg != 3'h0)));
endmodule

`default_nettype wire

// [static_mem_wait_state_inserter_tb_top.sv]
/*
 * Self-checking bench of the wait-state inserter.
 * Assumes the memory model in its own file; inputs move 2 ns after an edge.
 */
`default_nettype none

module static_mem_wait_state_inserter_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Signals and design
    // ----------------------------------------
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    smwi_pkg::smwi_cfg_type cfg [8];
    logic req_valid = 1'b0;
    smwi_pkg::smwi_req_type req = 5'h00;
    logic req_ready, access_end, mode_wr, slow, fb_n, strobes_off, load_cfg, late_r;
    logic bus_hold, reload_pend;
    logic [3:0] float_rem;
    int holds = 0;
    smwi_pkg::smwi_wait_type kind;
    int bad_count = 0;
    int n_compared = 0;
    always #12.5 mclk_in = ~mclk_in;
    smwi_wait_inserter #(.NUM_CS(8)) dut_u (.mclk_in(mclk_in), .reset_in(reset_in),
        .cfg_in(cfg), .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready),
        .access_end_in(access_end), .mode_reg_write_in(mode_wr), .slow_clock_in(slow),
        .write_strobe_fb_n_in(fb_n), .strobes_off_out(strobes_off), .bus_hold_out(bus_hold),
        .load_config_out(load_cfg), .reload_pending_out(reload_pend), .wait_kind_out(kind),
        .float_remaining_out(float_rem));
    smwi_mem_model mem_u (.mclk_in(mclk_in), .reset_in(reset_in),
        .take_in(req_valid & req_ready & !req.internal), .is_write_in(req.is_write),
        .late_in(late_r), .access_end_out(access_end), .fb_n_out(fb_n));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic results();
        if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic ok, input int exp, input int seen);
        n_compared++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("Error %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    // External access: counts inserted wait cycles and reload loads until taken
    task automatic acc(input logic [2:0] cs, input logic wr, input logic late, input int lo,
            input int hi, input logic [4:0] msk, input logic [4:0] exp, input int ld);
        int n, k, l;
        logic got;
        n = 0;
        l = 0;
        got = 1'b0;
        holds = 0;
        @(posedge mclk_in) #2;
        req_valid = 1'b1;
        req = {cs, wr, 1'b0};
        late_r = late;
        for (k = 0; k < 40 && !got; k++) begin
            @(negedge mclk_in);
            if (strobes_off === 1'b1) n++;
            if (load_cfg === 1'b1) l++;
            if (bus_hold === 1'b1) holds++;
            if (req_ready === 1'b1) got = 1'b1;
        end
        if (!got) begin
            chk("req_ready", 1'b0, 1, 0);
            results();
        end
        chk("wait_cycles", n >= lo && n <= hi, lo, n);
        if (ld >= 0) chk("load_config", l == ld, ld, l);
        @(posedge mclk_in) #2;
        req_valid = 1'b0;
        // Reasons register only at the deciding edge, the taking edge when no wait
        chk("wait_kind", (kind & msk) === exp, exp, kind & msk);
        got = 1'b0;
        for (k = 0; k < 20 && !got; k++) begin
            @(negedge mclk_in);
            if (access_end === 1'b1) got = 1'b1;
        end
        if (!got) begin
            chk("access_end", 1'b0, 1, 0);
            results();
        end
    endtask
    // A mode register write, seen as a one-cycle pulse
    task automatic mode_write();
        @(posedge mclk_in) #2 mode_wr = 1'b1;
        @(posedge mclk_in) #2 mode_wr = 1'b0;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        mode_wr = 1'b0;
        slow = 1'b0;
        late_r = 1'b0;
        // Strobe-controlled, no float, every timing one cycle
        for (int i = 0; i < 8; i++) cfg[i] = {3'h6, 4'h0, {8{8'h01}}};
        cfg[0].write_strobe_hold = 8'h00;
        cfg[0].read_strobe_setup = 8'h00;
        cfg[1].read_strobe_setup = 8'h00;
        cfg[3].write_ctrl_sel = 1'b0;
        cfg[3].cs_write_hold = 8'h00;
        cfg[3].cs_read_setup = 8'h00;
        cfg[2].write_strobe_hold = 8'h00;
        cfg[4].float_cycles = 4'h5;
        cfg[5] = {3'h7, 4'h3, {8{8'h01}}};
        cfg[5].write_strobe_setup = 8'h08;
        repeat (8) @(posedge mclk_in);
        #2 reset_in = 1'b0;
        acc(3'h0, 1'b1, 1'b0, 0, 0, 5'h1f, 5'h00, 0);
        acc(3'h0, 1'b0, 1'b0, 1, 1, 5'h1f, 5'h04, 0);
        acc(3'h0, 1'b1, 1'b0, 1, 1, 5'h1e, 5'h02, 0);
        acc(3'h0, 1'b0, 1'b0, 1, 1, 5'h1e, 5'h04, -1);
        acc(3'h1, 1'b0, 1'b0, 1, 1, 5'h1e, 5'h10, 0);
        // A timing change alone must not arm a reload
        @(posedge mclk_in) #2 cfg[1].read_strobe_hold = 8'h02;
        chk("reload_pending", reload_pend === 1'b0, 0, reload_pend);
        mode_write();
        chk("reload_pending", reload_pend === 1'b1, 1, reload_pend);
        acc(3'h1, 1'b0, 1'b0, 1, 1, 5'h1f, 5'h08, 1);
        mode_write();
        acc(3'h0, 1'b1, 1'b0, 2, 2, 5'h12, 5'h12, -1);
        @(posedge mclk_in) #2 slow = 1'b1;
        acc(3'h0, 1'b1, 1'b0, 1, 1, 5'h1f, 5'h08, 1);
        @(posedge mclk_in) #2 slow = 1'b0;
        acc(3'h3, 1'b1, 1'b0, 1, 1, 5'h1f, 5'h10, 1);
        acc(3'h3, 1'b0, 1'b0, 1, 1, 5'h1f, 5'h04, 0);
        acc(3'h2, 1'b1, 1'b0, 2, 2, 5'h1f, 5'h12, -1);
        acc(3'h2, 1'b0, 1'b0, 0, 0, 5'h1f, 5'h00, 0);
        chk("bus_hold", holds == 0, 0, holds);
        acc(3'h2, 1'b1, 1'b1, 1, 1, 5'h1e, 5'h02, -1);
        acc(3'h2, 1'b0, 1'b0, 1, 1, 5'h1f, 5'h04, 0);
        chk("bus_hold", holds > 0, 1, holds);
        acc(3'h4, 1'b0, 1'b0, 1, 1, 5'h1e, 5'h10, -1);
        // Internal request straight after a long-float read is not held back
        @(posedge mclk_in) #2;
        req_valid = 1'b1;
        req = 5'h01;
        @(negedge mclk_in);
        chk("internal_ready", req_ready === 1'b1, 1, req_ready);
        // Five float cycles less the one read hold cycle already spent
        chk("float_remaining", float_rem === 4'h4, 4, float_rem);
        @(posedge mclk_in) #2 req_valid = 1'b0;
        acc(3'h4, 1'b1, 1'b0, 2, 4, 5'h01, 5'h01, -1);
        acc(3'h5, 1'b0, 1'b0, 1, 1, 5'h1f, 5'h10, -1);
        acc(3'h5, 1'b1, 1'b0, 1, 1, 5'h03, 5'h02, -1);
        results();
    end
endmodule

`default_nettype wire
